// ---- core/dtcc_pkg.sv ----
// Purpose: shared constants of the dual time base capture/compare block
// Assumes: 16-bit register port, word addressed, 64 locations
// Notes: compare modes live in the function field of each channel mode register
package dtcc_pkg;

  // sizes
  localparam int DW = 16;
  localparam int AW = 6;
  localparam int NCH = 16;
  localparam int NPAIR = 8;
  localparam int PRE_W = 9;
  localparam int STAG_SLOTS = 8;

  // register offsets
  localparam logic [5:0] OFS_TMR0 = 6'h00;
  localparam logic [5:0] OFS_TMR1 = 6'h01;
  localparam logic [5:0] OFS_REL0 = 6'h02;
  localparam logic [5:0] OFS_REL1 = 6'h03;
  localparam logic [5:0] OFS_TCON = 6'h04;
  localparam logic [5:0] OFS_STAT = 6'h05;
  localparam logic [5:0] OFS_MASK = 6'h06;
  localparam logic [5:0] OFS_DREG = 6'h07;
  localparam logic [1:0] OFS_MODE_BANK = 2'h1;
  localparam logic [1:0] OFS_VAL_BANK = 2'h2;

  // timer control fields, timer 1 sits eight bits above timer 0
  localparam int TCON_RUN_POS = 0;
  localparam int TCON_SEL_POS = 1;
  localparam int TCON_T1_SHIFT = 8;
  localparam int TCON_STAG_POS = 15;

  // channel mode fields
  localparam int MODE_FN_POS = 0;
  localparam int MODE_TSEL_POS = 3;
  localparam int MODE_SEV_POS = 4;

  // channel functions
  localparam logic [2:0] FN_OFF = 3'h0;
  localparam logic [2:0] FN_CAP_RISE = 3'h1;
  localparam logic [2:0] FN_CAP_FALL = 3'h2;
  localparam logic [2:0] FN_CAP_BOTH = 3'h3;
  localparam logic [2:0] FN_CMP0 = 3'h4;
  localparam logic [2:0] FN_CMP1 = 3'h5;
  localparam logic [2:0] FN_CMP2 = 3'h6;
  localparam logic [2:0] FN_CMP3 = 3'h7;

  // count clock sources
  localparam logic [2:0] SEL_DIV1 = 3'h0;
  localparam logic [2:0] SEL_DIV8 = 3'h1;
  localparam logic [2:0] SEL_DIV64 = 3'h2;
  localparam logic [2:0] SEL_DIV512 = 3'h3;
  localparam logic [2:0] SEL_GPT = 3'h4;
  localparam logic [2:0] SEL_EXT = 3'h5;

  // values after reset and the count limit
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [4:0] RST_MODE = 5'h00;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

endpackage

// ---- core/dtcc_tbase_if.sv ----
// Purpose: carries one time base between the control logic and its timer
// Assumes: all signals on ref_clk
// Notes: ovf is a one-cycle pulse in the cycle the reload happens
`timescale 1ns/1ps
interface dtcc_tbase_if;
  logic tick;
  logic load;
  logic [15:0] load_val;
  logic [15:0] reload;
  logic [15:0] count;
  logic ovf;
  logic upd;
  modport tmr (input tick, input load, input load_val, input reload, output count, output ovf, output upd);
  modport ctl (output tick, output load, output load_val, output reload, input count, input ovf, input upd);
endinterface

// ---- core/dtcc_timer.sv ----
// Purpose: one 16-bit up counting time base with reload on overflow
// Assumes: tick is a one-cycle pulse on ref_clk
// Notes: upd flags the cycle in which a fresh count value is visible
`timescale 1ns/1ps
module dtcc_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // time base link
  dtcc_tbase_if.tmr tb
);

  logic [15:0] cnt_r;
  logic upd_r;
  logic wrap;

  ////////////////////////////////////////////////////////////////////////
  // overflow decode
  assign wrap = tb.tick && !tb.load && (cnt_r == dtcc_pkg::CNT_MAX);
  assign tb.ovf = wrap;
  assign tb.count = cnt_r;
  assign tb.upd = upd_r;

  // count, software load, reload on wrap
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cnt_r <= dtcc_pkg::RST_WORD;
      upd_r <= 1'b0;
    end
    else
    begin
      upd_r <= tb.load | tb.tick;
      if (tb.load)
        cnt_r <= tb.load_val;
      else if (wrap)
        cnt_r <= tb.reload;
      else if (tb.tick)
        cnt_r <= cnt_r + 16'h0001;
    end
  end

endmodule

// ---- core/dtcc_pin_sync.sv ----
// Purpose: three-stage synchroniser with agreement filter and edge pulses
// Assumes: inputs are asynchronous to ref_clk
// Notes: a change is accepted once stages two and three agree
`timescale 1ns/1ps
module dtcc_pin_sync #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // raw and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] s1_r, s2_r, s3_r, lvl_r, rise_r, fall_r;
  wire [W-1:0] agree = ~(s2_r ^ s3_r);
  wire [W-1:0] lvl_nxt = (s3_r & agree) | (lvl_r & ~agree);

  // elaboration guard on the width
  if (W < 1)
  begin : g_width_chk
    $error("width must be at least one");
  end

  // sync chain and edge pulses
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
      rise_r <= '0;
      fall_r <= '0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      rise_r <= lvl_nxt & ~lvl_r;
      fall_r <= ~lvl_nxt & lvl_r;
    end
  end

  assign lvl = lvl_r;
  assign rise = rise_r;
  assign fall = fall_r;

endmodule

// ---- core/dtcc_top.sv ----
// Purpose: sixteen-channel capture/compare array on two reloadable time bases
// Assumes: 40 MHz ref_clk, synchronous active-low reset, plain register port
// Notes: pins and external count inputs are synchronised inside
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
// How it works
// - sixteen channels act with one-clock resolution, or eight clocks when staggering is on.
// - two independent 16-bit timers each have their own reload register.
// - each timer counts on a prescaled system clock or on the general timer six overflow pulse.
// - each timer can instead count edges of its external count input.
// - sixteen channel registers each choose a timer and capture or compare on their own.
// - each channel owns one pin, input while capturing and output while comparing.
// - a qualifying pin edge copies the assigned timer into a capturing channel.
// - every capture sets that channel's own interrupt request.
// - the capture edge is rising, falling or both, per channel.
// - compare channels are checked against their timer on every new count and act on a match.
// - mode 0 only requests an interrupt, as often as matches occur.
// - mode 1 toggles the pin on each match.
// - mode 2 requests an interrupt at most once per timer period.
// - mode 3 sets the pin on a match and clears it on timer overflow, once per period.
// - a double-register pair toggles one shared pin on a match of either channel.
// - a single-event option turns the channel off after its first compare event.
module dtcc_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // count sources
  input wire logic gpt6_ovf_pulse,
  input wire logic [1:0] ext_count_in,
  // channel pins
  input wire logic [15:0] cc_pin_in,
  output logic [15:0] cc_pin_out,
  output logic [15:0] cc_pin_oe,
  // interrupt
  output logic irq
);

  localparam int N = dtcc_pkg::NCH;
  localparam int NP = dtcc_pkg::NPAIR;

  ////////////////////////////////////////////////////////////////////////
  // storage
  logic [15:0] rel_r [2];
  logic [15:0] tcon_r;
  logic [15:0] stat_r, stat_nxt;
  logic [15:0] mask_r;
  logic [7:0] dreg_r;
  logic [4:0] mode_r [N];
  logic [4:0] mode_nxt [N];
  logic [15:0] val_r [N];
  logic [15:0] val_nxt [N];
  logic [15:0] pin_r, pin_nxt;
  logic [15:0] done_r, done_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rd_nxt;
  logic [dtcc_pkg::PRE_W-1:0] pre_r;
  logic [2:0] slot_r;
  logic [1:0] pend_r, pend_nxt;

  // synchronised inputs
  logic [15:0] pin_rise, pin_fall;
  logic [1:0] ext_rise;

  // per channel decode
  logic [15:0] cap_ev, cmp_ev, match;
  logic [15:0] tick_src;
  logic [1:0] src, tick, ovf, upd;
  logic [15:0] cnt [2];

  dtcc_tbase_if tb0 ();
  dtcc_tbase_if tb1 ();

  // elaboration guard on the array shape
  if (N != 16 || NP * 2 != N)
  begin : g_shape_chk
    $error("array must hold sixteen channels in eight pairs");
  end

  ////////////////////////////////////////////////////////////////////////
  // prescale decode, one tick per selected period
  function automatic logic div_tick(input logic [2:0] sel, input logic [dtcc_pkg::PRE_W-1:0] pre,
                                    input logic gpt, input logic ext);
    logic t;
    t = 1'b0;
    case (sel)
      dtcc_pkg::SEL_DIV1: t = 1'b1;
      dtcc_pkg::SEL_DIV8: t = (pre[2:0] == 3'h0);
      dtcc_pkg::SEL_DIV64: t = (pre[5:0] == 6'h00);
      dtcc_pkg::SEL_DIV512: t = (pre[8:0] == 9'h000);
      dtcc_pkg::SEL_GPT: t = gpt;
      dtcc_pkg::SEL_EXT: t = ext;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  dtcc_pin_sync #(.W(16)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raw(cc_pin_in),
    .lvl(),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  dtcc_pin_sync #(.W(2)) u_ext_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raw(ext_count_in),
    .lvl(),
    .rise(ext_rise),
    .fall()
  );

  ////////////////////////////////////////////////////////////////////////
  // register decode
  wire stag_on = tcon_r[dtcc_pkg::TCON_STAG_POS];
  wire [3:0] idx = reg_addr[3:0];
  wire wr_tmr0 = reg_wr && (reg_addr == dtcc_pkg::OFS_TMR0);
  wire wr_tmr1 = reg_wr && (reg_addr == dtcc_pkg::OFS_TMR1);
  wire wr_rel0 = reg_wr && (reg_addr == dtcc_pkg::OFS_REL0);
  wire wr_rel1 = reg_wr && (reg_addr == dtcc_pkg::OFS_REL1);
  wire wr_tcon = reg_wr && (reg_addr == dtcc_pkg::OFS_TCON);
  wire wr_stat = reg_wr && (reg_addr == dtcc_pkg::OFS_STAT);
  wire wr_mask = reg_wr && (reg_addr == dtcc_pkg::OFS_MASK);
  wire wr_dreg = reg_wr && (reg_addr == dtcc_pkg::OFS_DREG);
  wire wr_mode = reg_wr && (reg_addr[5:4] == dtcc_pkg::OFS_MODE_BANK);
  wire wr_val = reg_wr && (reg_addr[5:4] == dtcc_pkg::OFS_VAL_BANK);
  wire slot_ok = !stag_on || (slot_r == 3'h0);

  ////////////////////////////////////////////////////////////////////////
  // count clock selection per timer
  assign src[0] = div_tick(tcon_r[dtcc_pkg::TCON_SEL_POS +: 3], pre_r, gpt6_ovf_pulse, ext_rise[0]);
  assign src[1] = div_tick(tcon_r[dtcc_pkg::TCON_T1_SHIFT + dtcc_pkg::TCON_SEL_POS +: 3], pre_r,
                           gpt6_ovf_pulse, ext_rise[1]);
  assign tick[0] = tcon_r[dtcc_pkg::TCON_RUN_POS] && slot_ok && (src[0] || pend_r[0]);
  assign tick[1] = tcon_r[dtcc_pkg::TCON_T1_SHIFT + dtcc_pkg::TCON_RUN_POS] && slot_ok
                   && (src[1] || pend_r[1]);
  assign pend_nxt = slot_ok ? 2'b00 : (pend_r | (src & {tcon_r[dtcc_pkg::TCON_T1_SHIFT + dtcc_pkg::TCON_RUN_POS],
                                                        tcon_r[dtcc_pkg::TCON_RUN_POS]}));

  ////////////////////////////////////////////////////////////////////////
  // two time bases
  assign tb0.tick = tick[0];
  assign tb0.load = wr_tmr0;
  assign tb0.load_val = reg_wdata;
  assign tb0.reload = rel_r[0];
  assign tb1.tick = tick[1];
  assign tb1.load = wr_tmr1;
  assign tb1.load_val = reg_wdata;
  assign tb1.reload = rel_r[1];
  assign cnt[0] = tb0.count;
  assign cnt[1] = tb1.count;
  assign ovf = {tb1.ovf, tb0.ovf};
  assign upd = {tb1.upd, tb0.upd};

  dtcc_timer u_tmr0 (.ref_clk(ref_clk), .rst_b(rst_b), .tb(tb0.tmr));
  dtcc_timer u_tmr1 (.ref_clk(ref_clk), .rst_b(rst_b), .tb(tb1.tmr));

  ////////////////////////////////////////////////////////////////////////
  // channel events
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      logic [2:0] fn;
      logic ts;
      fn = mode_r[i][dtcc_pkg::MODE_FN_POS +: 3];
      ts = mode_r[i][dtcc_pkg::MODE_TSEL_POS];
      cap_ev[i] = ((fn == dtcc_pkg::FN_CAP_RISE || fn == dtcc_pkg::FN_CAP_BOTH) && pin_rise[i])
                  || ((fn == dtcc_pkg::FN_CAP_FALL || fn == dtcc_pkg::FN_CAP_BOTH) && pin_fall[i]);
      match[i] = fn[2] && upd[ts] && (cnt[ts] == val_r[i]);
      cmp_ev[i] = match[i] && !((fn == dtcc_pkg::FN_CMP2 || fn == dtcc_pkg::FN_CMP3) && done_r[i]);
      tick_src[i] = ovf[ts];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel next state: value, mode, pin, once-per-period flag
  always_comb
  begin
    pin_nxt = pin_r;
    done_nxt = done_r;
    for (int i = 0; i < N; i++)
    begin
      logic [2:0] fn;
      logic ts;
      fn = mode_r[i][dtcc_pkg::MODE_FN_POS +: 3];
      ts = mode_r[i][dtcc_pkg::MODE_TSEL_POS];
      val_nxt[i] = (wr_val && idx == 4'(i)) ? reg_wdata : val_r[i];
      mode_nxt[i] = (wr_mode && idx == 4'(i)) ? reg_wdata[4:0] : mode_r[i];
      if (cap_ev[i])
        val_nxt[i] = cnt[ts];
      if (tick_src[i])
        done_nxt[i] = 1'b0;
      if (cmp_ev[i])
        done_nxt[i] = 1'b1;
      if (fn == dtcc_pkg::FN_CMP1 && cmp_ev[i])
        pin_nxt[i] = ~pin_r[i];
      if (fn == dtcc_pkg::FN_CMP3 && tick_src[i])
        pin_nxt[i] = 1'b0;
      if (fn == dtcc_pkg::FN_CMP3 && cmp_ev[i])
        pin_nxt[i] = 1'b1;
      if (cmp_ev[i] && mode_r[i][dtcc_pkg::MODE_SEV_POS])
        mode_nxt[i] = dtcc_pkg::RST_MODE;
    end
    // pair k with k+8 on pin k
    for (int k = 0; k < NP; k++)
    begin
      if (dreg_r[k] && cmp_ev[k + NP])
        pin_nxt[k] = ~pin_nxt[k];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive enables: compare channels drive, pair slaves do not
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (i < NP)
        cc_pin_oe[i] = mode_r[i][2] || dreg_r[i % NP];
      else
        cc_pin_oe[i] = mode_r[i][2] && !dreg_r[i % NP];
    end
  end

  // sticky requests, set wins over a write-one clear
  assign stat_nxt = (wr_stat ? (stat_r & ~reg_wdata) : stat_r) | cap_ev | cmp_ev;

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb
  begin
    rd_nxt = 16'h0000;
    case (reg_addr[5:4])
      dtcc_pkg::OFS_MODE_BANK: rd_nxt = {11'h000, mode_r[idx]};
      dtcc_pkg::OFS_VAL_BANK: rd_nxt = val_r[idx];
      2'h0:
      begin
        case (reg_addr)
          dtcc_pkg::OFS_TMR0: rd_nxt = cnt[0];
          dtcc_pkg::OFS_TMR1: rd_nxt = cnt[1];
          dtcc_pkg::OFS_REL0: rd_nxt = rel_r[0];
          dtcc_pkg::OFS_REL1: rd_nxt = rel_r[1];
          dtcc_pkg::OFS_TCON: rd_nxt = tcon_r;
          dtcc_pkg::OFS_STAT: rd_nxt = stat_r;
          dtcc_pkg::OFS_MASK: rd_nxt = mask_r;
          dtcc_pkg::OFS_DREG: rd_nxt = {8'h00, dreg_r};
          default: rd_nxt = 16'h0000;
        endcase
      end
      default: rd_nxt = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rel_r[0] <= dtcc_pkg::RST_WORD;
      rel_r[1] <= dtcc_pkg::RST_WORD;
      tcon_r <= dtcc_pkg::RST_WORD;
      mask_r <= dtcc_pkg::RST_WORD;
      dreg_r <= 8'h00;
    end
    else
    begin
      if (wr_rel0)
        rel_r[0] <= reg_wdata;
      if (wr_rel1)
        rel_r[1] <= reg_wdata;
      if (wr_tcon)
        tcon_r <= reg_wdata;
      if (wr_mask)
        mask_r <= reg_wdata;
      if (wr_dreg)
        dreg_r <= reg_wdata[7:0];
    end
  end

  // status, pins, flags, prescaler, stagger slot, read data
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      stat_r <= dtcc_pkg::RST_WORD;
      pin_r <= dtcc_pkg::RST_WORD;
      done_r <= dtcc_pkg::RST_WORD;
      rdata_r <= dtcc_pkg::RST_WORD;
      pre_r <= '0;
      slot_r <= 3'h0;
      pend_r <= 2'b00;
    end
    else
    begin
      stat_r <= stat_nxt;
      pin_r <= pin_nxt;
      done_r <= done_nxt;
      rdata_r <= reg_rd ? rd_nxt : 16'h0000;
      pre_r <= pre_r + 1'b1;
      slot_r <= slot_r + 3'h1;
      pend_r <= pend_nxt;
    end
  end

  // channel array
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (!rst_b)
      begin
        mode_r[i] <= dtcc_pkg::RST_MODE;
        val_r[i] <= dtcc_pkg::RST_WORD;
      end
      else
      begin
        mode_r[i] <= mode_nxt[i];
        val_r[i] <= val_nxt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata = rdata_r;
  assign cc_pin_out = pin_r;
  assign irq = |(stat_r & mask_r);

endmodule

// ---- bench/dtcc_properties.sv ----
// Purpose: port-level properties of the capture/compare block
// Assumes: one ref_clk domain, rst_b synchronous and active low
// Notes: mask, timer control, channel kind and pairing are mirrored from bus writes
`timescale 1ns/1ps
module dtcc_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // count sources and pins
  input wire logic gpt6_ovf_pulse,
  input wire logic [1:0] ext_count_in,
  input wire logic [15:0] cc_pin_in,
  input wire logic [15:0] cc_pin_out,
  input wire logic [15:0] cc_pin_oe,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] mask_r;
  logic [15:0] tcon_r;
  logic [15:0] cap_r;
  logic [7:0] dreg_r;
  logic [2:0] quiet_r;
  // decoded writes and derived conditions
  wire wr_mode = reg_wr && (reg_addr[5:4] == dtcc_pkg::OFS_MODE_BANK);
  wire rd_mode = reg_rd && (reg_addr[5:4] == dtcc_pkg::OFS_MODE_BANK);
  wire stopped = !tcon_r[0] && !tcon_r[8];
  // mirror of software state, quiet_r counts cycles since the last write, holding at seven
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      mask_r <= 16'h0000;
      tcon_r <= 16'h0000;
      cap_r <= 16'hFFFF;
      dreg_r <= 8'h00;
      quiet_r <= 3'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == dtcc_pkg::OFS_MASK) mask_r <= reg_wdata;
      if (reg_wr && reg_addr == dtcc_pkg::OFS_TCON) tcon_r <= reg_wdata;
      if (reg_wr && reg_addr == dtcc_pkg::OFS_DREG) dreg_r <= reg_wdata[7:0];
      if (wr_mode) cap_r[reg_addr[3:0]] <= !reg_wdata[2];
      if (reg_wr) quiet_r <= 3'h0;
      else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
    end
  end
  // read of a hole in the map
  sequence s_unmapped_rd;
    reg_rd && (reg_addr[5:3] == 3'h1 || reg_addr[5:4] == 2'h3);
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_unmapped_read_zero: assert property (s_unmapped_rd |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
  a_mode_read_width: assert property (rd_mode |=> reg_rdata[15:5] == 11'h000)
    else $error("mode read has upper bits set");
  a_pair_read_width: assert property (reg_rd && reg_addr == dtcc_pkg::OFS_DREG |=> reg_rdata[15:8] == 8'h00)
    else $error("pair register read has upper bits set");
  a_reset_quiet_pins: assert property ($rose(rst_b) |-> cc_pin_out == 16'h0000 && cc_pin_oe == 16'h0000 && !irq)
    else $error("pins or irq active after reset");
  a_irq_all_masked: assert property (mask_r == 16'h0000 |-> !irq)
    else $error("irq high with all sources masked");
  a_capture_not_driven: assert property ((cc_pin_oe & cap_r & ~{8'h00, dreg_r}) == 16'h0000)
    else $error("capture channel drives its pin");
  a_pair_slave_off: assert property ((cc_pin_oe[15:8] & dreg_r) == 8'h00)
    else $error("paired upper channel drives its pin");
  a_pins_still_idle: assert property (stopped && quiet_r == 3'h7 |-> $stable(cc_pin_out))
    else $error("pin changed with timers stopped");
endmodule
bind dtcc_top dtcc_properties u_props (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .gpt6_ovf_pulse(gpt6_ovf_pulse), .ext_count_in(ext_count_in), .cc_pin_in(cc_pin_in),
  .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .irq(irq));

// ---- bench/dtcc_pin_model.sv ----
// Purpose: outside world on the sixteen channel pins
// Assumes: undriven pins are driven from outside to ext_lvl
// Notes: a pin the block drives reads back the block's own level
`timescale 1ns/1ps
module dtcc_pin_model (
  // pins of the block
  input wire logic [15:0] cc_pin_out,
  input wire logic [15:0] cc_pin_oe,
  output logic [15:0] cc_pin_in,
  // outside levels
  input wire logic [15:0] ext_lvl
);
  // wire level from the block's enable alone
  assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & ext_lvl);
endmodule

// ---- bench/testbench.sv ----
// Purpose: self-checking bench of the capture/compare block
// Assumes: 40 MHz ref_clk, timer 0 stepped by the general timer pulse, timer 1 by its external input and the prescaler
// Notes: expectations follow from counts that the bench itself issues
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic gpt6_ovf_pulse = 1'b0;
  logic [1:0] ext_count_in = 2'h0;
  logic [15:0] ext_lvl = 16'h0000;
  wire [15:0] reg_rdata;
  wire [15:0] cc_pin_in;
  wire [15:0] cc_pin_out;
  wire [15:0] cc_pin_oe;
  wire irq;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // design and outside pins
  dtcc_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpt6_ovf_pulse(gpt6_ovf_pulse),
    .ext_count_in(ext_count_in), .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .irq(irq));
  dtcc_pin_model u_pins (.cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .cc_pin_in(cc_pin_in), .ext_lvl(ext_lvl));
  // clock and hang guard
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_count++;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string n);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] exp, input string n);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, n);
  endtask
  task automatic gpt_pulse;
    @(posedge ref_clk);
    gpt6_ovf_pulse <= 1'b1;
    @(posedge ref_clk);
    gpt6_ovf_pulse <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic settle;
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [15:0] md(input logic [2:0] fn, input logic ts, input logic se);
    return {11'h000, se, ts, fn};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(dtcc_pkg::OFS_TMR1, dtcc_pkg::RST_WORD, "timer1");
    rdc(dtcc_pkg::OFS_REL0, dtcc_pkg::RST_WORD, "reload0");
    rdc(dtcc_pkg::OFS_TCON, dtcc_pkg::RST_WORD, "tcon");
    rdc(dtcc_pkg::OFS_STAT, dtcc_pkg::RST_WORD, "stat");
    rdc(6'h1F, {11'h000, dtcc_pkg::RST_MODE}, "mode15");
    wr(6'h09, 16'hA5A5);
    rdc(6'h09, 16'h0000, "hole low");
    wr(6'h3F, 16'h5A5A);
    rdc(6'h3F, 16'h0000, "hole high");
    chk(cc_pin_oe, 16'h0000, "oe after reset");
    $display("test reset done");
  endtask
  task automatic t_timers;
    wr(dtcc_pkg::OFS_REL0, 16'h1234);
    wr(dtcc_pkg::OFS_TMR0, 16'hFFFE);
    wr(dtcc_pkg::OFS_TCON, {4'h0, dtcc_pkg::SEL_EXT, 1'b1, 4'h0, dtcc_pkg::SEL_GPT, 1'b1});
    repeat (3) gpt_pulse;
    rdc(dtcc_pkg::OFS_TMR0, 16'h1235, "timer0 after reload");
    repeat (4)
    begin
      @(posedge ref_clk);
      ext_count_in <= 2'h2;
      repeat (6) @(posedge ref_clk);
      ext_count_in <= 2'h0;
      repeat (6) @(posedge ref_clk);
    end
    rdc(dtcc_pkg::OFS_TMR1, 16'h0004, "timer1 external");
    $display("test timers done");
  endtask
  task automatic t_capture;
    wr(6'h12, md(dtcc_pkg::FN_CAP_RISE, 1'b0, 1'b0));
    wr(6'h13, md(dtcc_pkg::FN_CAP_FALL, 1'b1, 1'b0));
    wr(6'h14, md(dtcc_pkg::FN_CAP_BOTH, 1'b0, 1'b0));
    @(posedge ref_clk);
    ext_lvl <= 16'h001C;
    settle;
    rdc(6'h22, 16'h1235, "rise capture");
    rdc(6'h23, 16'h0000, "fall ignores rise");
    rdc(6'h24, 16'h1235, "both on rise");
    rdc(dtcc_pkg::OFS_STAT, 16'h0014, "stat rise");
    wr(dtcc_pkg::OFS_MASK, 16'h0014);
    #1;
    chk({15'h0000, irq}, 16'h0001, "irq unmasked");
    gpt_pulse;
    ext_lvl <= 16'h0000;
    settle;
    rdc(6'h22, 16'h1235, "rise ignores fall");
    rdc(6'h23, 16'h0004, "fall on timer1");
    rdc(6'h24, 16'h1236, "both on fall");
    rdc(dtcc_pkg::OFS_STAT, 16'h001C, "stat fall");
    wr(dtcc_pkg::OFS_STAT, 16'h001C);
    #1;
    chk({15'h0000, irq}, 16'h0000, "irq cleared");
    $display("test capture done");
  endtask
  task automatic t_compare;
    for (int i = 5; i < 9; i++)
    begin
      wr({dtcc_pkg::OFS_VAL_BANK, i[3:0]}, 16'h0100);
      wr({dtcc_pkg::OFS_MODE_BANK, i[3:0]}, md(3'(i - 1), 1'b0, 1'b0));
    end
    wr(6'h21, 16'h0100);
    wr(6'h11, md(dtcc_pkg::FN_CMP1, 1'b0, 1'b0));
    wr(6'h29, 16'h0101);
    wr(6'h19, md(dtcc_pkg::FN_CMP0, 1'b0, 1'b0));
    wr(6'h2A, 16'h0100);
    wr(6'h1A, md(dtcc_pkg::FN_CMP1, 1'b0, 1'b1));
    wr(dtcc_pkg::OFS_DREG, 16'h0002);
    wr(dtcc_pkg::OFS_STAT, 16'hFFFF);
    wr(dtcc_pkg::OFS_TMR0, 16'h00FF);
    gpt_pulse;
    settle;
    chk(cc_pin_out, 16'h0542, "pins first match");
    rdc(dtcc_pkg::OFS_STAT, 16'h05E2, "stat first match");
    rdc(6'h1A, 16'h0000, "single event off");
    gpt_pulse;
    settle;
    chk(cc_pin_out, 16'h0540, "pair second toggle");
    rdc(dtcc_pkg::OFS_STAT, 16'h07E2, "stat pair");
    wr(dtcc_pkg::OFS_STAT, 16'hFFFF);
    wr(dtcc_pkg::OFS_TMR0, 16'h0100);
    settle;
    rdc(dtcc_pkg::OFS_STAT, 16'h0062, "stat same period");
    chk(cc_pin_out, 16'h0502, "pins same period");
    wr(dtcc_pkg::OFS_REL0, 16'h0000);
    wr(dtcc_pkg::OFS_TMR0, 16'hFFFF);
    gpt_pulse;
    settle;
    chk(cc_pin_out, 16'h0402, "overflow clears");
    wr(dtcc_pkg::OFS_STAT, 16'hFFFF);
    wr(dtcc_pkg::OFS_TMR0, 16'h0100);
    settle;
    rdc(dtcc_pkg::OFS_STAT, 16'h01E2, "stat new period");
    chk(cc_pin_out, 16'h0540, "pins new period");
    chk(cc_pin_oe, 16'h01E2, "oe compare");
    chk({15'h0000, irq}, 16'h0000, "irq masked");
    wr(dtcc_pkg::OFS_MASK, 16'h0020);
    #1;
    chk({15'h0000, irq}, 16'h0001, "irq compare");
    wr(dtcc_pkg::OFS_MASK, 16'h0000);
    $display("test compare done");
  endtask
  // 64 edges between load and read: eight ticks at /8, eight staggered ticks at /1
  task automatic t_prescale;
    wr(dtcc_pkg::OFS_TCON, {1'b0, 3'h0, dtcc_pkg::SEL_DIV8, 1'b1, 8'h00});
    wr(dtcc_pkg::OFS_TMR1, 16'h0000);
    repeat (63) @(posedge ref_clk);
    rdc(dtcc_pkg::OFS_TMR1, 16'h0008, "timer1 div8");
    wr(dtcc_pkg::OFS_TCON, {1'b1, 3'h0, dtcc_pkg::SEL_DIV1, 1'b1, 8'h00});
    wr(dtcc_pkg::OFS_TMR1, 16'h0000);
    repeat (63) @(posedge ref_clk);
    rdc(dtcc_pkg::OFS_TMR1, 16'h0008, "timer1 staggered");
    $display("test prescale done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset;
    t_timers;
    t_capture;
    t_compare;
    t_prescale;
    tally_and_finish;
  end
endmodule
